// ### rtl/lcs_consts.svh
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define LCS_ADDR_CMD1 8'h00
`define LCS_ADDR_CMD2 8'h01
`define LCS_ADDR_DATA_LSB 8'h02
`define LCS_ADDR_DATA_MSB 8'h03
`define LCS_ADDR_TIMING 8'h08
`define LCS_ADDR_EXT_CMD 8'h09
`define LCS_ADDR_ONCE 8'h0A
`define LCS_ADDR_STATUS 8'h0B
// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define LCS_MODE_HI 7
`define LCS_MODE_LO 5
`define LCS_RES_HI 3
`define LCS_RES_LO 2
`define LCS_RANGE_HI 1
`define LCS_RANGE_LO 0
`define LCS_MODE_OFF 3'h0
`define LCS_MODE_ALS 3'h5
`define LCS_MODE_IR 3'h6
`define LCS_RES_16 2'h0
`define LCS_RES_12 2'h1
`define LCS_RES_8 2'h2
`define LCS_RES_4 2'h3
// ----------------------------------------
// reset values
// ----------------------------------------
`define LCS_RST_BYTE 8'h00
`define LCS_RST_DATA 16'h0000
`define LCS_RST_MODE 3'h0
`define LCS_RST_SEL 2'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define LCS_SYNC_STAGES 3
`endif

// ### rtl/lcs_integ_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lcs_integ_if;
   logic start;
   logic run;
   logic ext_mode;
   logic close;
   logic tick;
   logic charge;
   logic [1:0] res_sel;
   logic done;
   logic [15:0] result;
   modport ctl (output start, run, ext_mode, close, tick, charge, res_sel,
                input done, result);
   modport acc (input start, run, ext_mode, close, tick, charge, res_sel,
                output done, result);
endinterface
`default_nettype wire

// ### rtl/lcs_integrator.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.svh"
module lcs_integrator #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // sequencer side
   lcs_integ_if.acc bus
);
   logic [CNT_W-1:0] tick_cnt_reg;
   logic [15:0] acc_reg;
   logic [15:0] result_reg;
   logic done_reg;
   logic [CNT_W-1:0] last_tick;
   logic [15:0] acc_inc;
   logic finish;

   always_comb begin
      unique case (bus.res_sel)
         `LCS_RES_16: last_tick = CNT_W'(16'hFFFF);
         `LCS_RES_12: last_tick = CNT_W'(16'h0FFF);
         `LCS_RES_8: last_tick = CNT_W'(16'h00FF);
         `LCS_RES_4: last_tick = CNT_W'(16'h000F);
      endcase
   end

   // saturate at full scale rather than wrap
   assign acc_inc = (bus.charge && acc_reg != 16'hFFFF) ? acc_reg + 16'h0001 : acc_reg;
   assign finish = bus.run && (bus.close ||
                   (!bus.ext_mode && bus.tick && tick_cnt_reg == last_tick));

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_reg <= '0;
         acc_reg <= `LCS_RST_DATA;
         result_reg <= `LCS_RST_DATA;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (bus.start) begin
            tick_cnt_reg <= '0;
            acc_reg <= `LCS_RST_DATA;
         end else if (finish) begin
            result_reg <= acc_inc;
            acc_reg <= `LCS_RST_DATA;
            tick_cnt_reg <= '0;
            done_reg <= 1'b1;
         end else if (bus.run) begin
            acc_reg <= acc_inc;
            if (bus.tick && !bus.ext_mode) begin
               tick_cnt_reg <= tick_cnt_reg + CNT_W'(1);
            end
         end
      end
   end

   assign bus.done = done_reg;
   assign bus.result = result_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_internal_end_count: assert property (
      (bus.run && !bus.start && !bus.ext_mode && !bus.close && bus.tick &&
       tick_cnt_reg == last_tick) |=> done_reg && tick_cnt_reg == '0)
      else $error("internal period did not end at counter limit");
   a_no_early_end: assert property (
      (bus.run && !bus.ext_mode && !bus.close && tick_cnt_reg != last_tick) |=> !done_reg)
      else $error("period ended before counter limit");
endmodule
`default_nettype wire

// ### rtl/lcs_pkg.sv
`default_nettype none
package lcs_pkg;
   typedef enum logic {
      LCS_ST_OFF,
      LCS_ST_INTEG
   } lcs_state_t;
endpackage
`default_nettype wire

// ### rtl/lcs_sequencer.sv
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.svh"
// Function
// - conversions yield an unsigned 16-bit count readable by the host.
// - ambient or infrared array is converted as the active mode selects.
// - internal timing ends a period when the 4/8/12/16-bit oscillator count completes.
// - external timing integrates exactly between two consecutive timing commands.
// - host selects the measurement range; range one is the finest.
// - after reset the block is powered down with zero result data.
// - a one-time command converts once, powers down and keeps the result.
// - continuous mode converts repeatedly, overwriting the result each time.
// - a power-down command stops continuous conversion.
// - mode 000 is power-down, 101 continuous ambient, 110 continuous infrared.
// - result is read-only, low byte at 02h and high byte at 03h.
// - range comes from the two low bits of the second command register.
module lcs_sequencer #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // analog front end
   input wire logic osc_clk,
   input wire logic charge_pulse,
   output logic sensor_on,
   output logic ir_select,
   output logic integrating,
   output logic [1:0] range_sel
);
   lcs_integ_if integ ();

   lcs_pkg::lcs_state_t state_reg;
   logic [2:0] mode_reg;
   logic [1:0] range_reg;
   logic [1:0] res_reg;
   logic ext_reg;
   logic [15:0] data_reg;
   logic cont_reg;
   logic ir_reg;
   logic open_reg;
   logic on_reg;
   logic start_reg;
   logic close_reg;
   logic [7:0] rdata_reg;
   logic [`LCS_SYNC_STAGES-1:0] osc_sync_reg;
   logic [`LCS_SYNC_STAGES-1:0] chg_sync_reg;
   logic osc_lvl_reg;
   logic chg_lvl_reg;
   logic tick_reg;
   logic charge_reg;
   logic [2:0] wmode;
   logic wr_cmd1;
   logic wr_once;
   logic wr_ext;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   // a change counts only when stages two and three agree
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         osc_sync_reg <= '0;
         chg_sync_reg <= '0;
         osc_lvl_reg <= 1'b0;
         chg_lvl_reg <= 1'b0;
         tick_reg <= 1'b0;
         charge_reg <= 1'b0;
      end else begin
         osc_sync_reg <= {osc_sync_reg[1:0], osc_clk};
         chg_sync_reg <= {chg_sync_reg[1:0], charge_pulse};
         tick_reg <= 1'b0;
         charge_reg <= 1'b0;
         if (osc_sync_reg[1] == osc_sync_reg[2]) begin
            osc_lvl_reg <= osc_sync_reg[2];
            tick_reg <= osc_sync_reg[2] && !osc_lvl_reg;
         end
         if (chg_sync_reg[1] == chg_sync_reg[2]) begin
            chg_lvl_reg <= chg_sync_reg[2];
            charge_reg <= chg_sync_reg[2] && !chg_lvl_reg;
         end
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   assign wmode = wdata[`LCS_MODE_HI:`LCS_MODE_LO];
   assign wr_cmd1 = wr && addr == `LCS_ADDR_CMD1;
   assign wr_once = wr && addr == `LCS_ADDR_ONCE;
   assign wr_ext = wr && addr == `LCS_ADDR_EXT_CMD;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_reg <= `LCS_RST_MODE;
         range_reg <= `LCS_RST_SEL;
         res_reg <= `LCS_RST_SEL;
         ext_reg <= 1'b0;
      end else if (wr) begin
         if (addr == `LCS_ADDR_CMD1) begin
            mode_reg <= wmode;
         end
         if (addr == `LCS_ADDR_CMD2) begin
            range_reg <= wdata[`LCS_RANGE_HI:`LCS_RANGE_LO];
            res_reg <= wdata[`LCS_RES_HI:`LCS_RES_LO];
         end
         if (addr == `LCS_ADDR_TIMING) begin
            ext_reg <= wdata[0];
         end
      end
   end

   // ----------------------------------------
   // conversion sequencing
   // ----------------------------------------
   // commands take priority over a completion in the same cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= lcs_pkg::LCS_ST_OFF;
         on_reg <= 1'b0;
         cont_reg <= 1'b0;
         ir_reg <= 1'b0;
         open_reg <= 1'b0;
         start_reg <= 1'b0;
         close_reg <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         close_reg <= 1'b0;
         if (wr_cmd1 && wmode == `LCS_MODE_OFF) begin
            state_reg <= lcs_pkg::LCS_ST_OFF;
            on_reg <= 1'b0;
            open_reg <= 1'b0;
         end else if (wr_cmd1 && (wmode == `LCS_MODE_ALS || wmode == `LCS_MODE_IR)) begin
            state_reg <= lcs_pkg::LCS_ST_INTEG;
            on_reg <= 1'b1;
            cont_reg <= 1'b1;
            ir_reg <= wmode == `LCS_MODE_IR;
            start_reg <= 1'b1;
            open_reg <= !ext_reg;
         end else if (wr_once) begin
            state_reg <= lcs_pkg::LCS_ST_INTEG;
            on_reg <= 1'b1;
            cont_reg <= 1'b0;
            ir_reg <= wdata[0];
            start_reg <= 1'b1;
            open_reg <= !ext_reg;
         end else if (wr_ext && ext_reg && state_reg == lcs_pkg::LCS_ST_INTEG) begin
            if (!open_reg) begin
               open_reg <= 1'b1;
               start_reg <= 1'b1;
            end else begin
               close_reg <= 1'b1;
            end
         end else if (integ.done && state_reg == lcs_pkg::LCS_ST_INTEG && !cont_reg) begin
            state_reg <= lcs_pkg::LCS_ST_OFF;
            on_reg <= 1'b0;
            open_reg <= 1'b0;
         end
      end
   end

   // result update, held while powered down
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         data_reg <= `LCS_RST_DATA;
      end else if (integ.done && state_reg == lcs_pkg::LCS_ST_INTEG) begin
         data_reg <= integ.result;
      end
   end

   assign integ.start = start_reg;
   assign integ.run = open_reg;
   assign integ.ext_mode = ext_reg;
   assign integ.close = close_reg;
   assign integ.tick = tick_reg;
   assign integ.charge = charge_reg;
   assign integ.res_sel = res_reg;

   lcs_integrator #(
      .CNT_W(CNT_W)
   ) u_integ (
      .mclk(mclk),
      .nrst(nrst),
      .bus(integ)
   );

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   // data bytes are read only
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= `LCS_RST_BYTE;
      end else if (rd) begin
         unique case (addr)
            `LCS_ADDR_CMD1: rdata_reg <= {mode_reg, 5'h00};
            `LCS_ADDR_CMD2: rdata_reg <= {4'h0, res_reg, range_reg};
            `LCS_ADDR_DATA_LSB: rdata_reg <= data_reg[7:0];
            `LCS_ADDR_DATA_MSB: rdata_reg <= data_reg[15:8];
            `LCS_ADDR_TIMING: rdata_reg <= {7'h00, ext_reg};
            `LCS_ADDR_STATUS: rdata_reg <= {6'h00, open_reg, on_reg};
            default: rdata_reg <= `LCS_RST_BYTE;
         endcase
      end else begin
         rdata_reg <= `LCS_RST_BYTE;
      end
   end

   assign rdata = rdata_reg;
   assign sensor_on = on_reg;
   assign ir_select = ir_reg;
   assign integrating = open_reg;
   assign range_sel = range_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_close_cmd;
      wr_ext && ext_reg && open_reg && state_reg == lcs_pkg::LCS_ST_INTEG;
   endsequence
   sequence s_open_cmd;
      wr_ext && ext_reg && !open_reg && state_reg == lcs_pkg::LCS_ST_INTEG;
   endsequence
   // a close needs one quiet cycle so no other command lands on it
   sequence s_close_quiet;
      s_close_cmd ##1 !wr;
   endsequence
   sequence s_latch_done;
      integ.done && integrating ##1 data_reg == $past(integ.result);
   endsequence

   // c1 close strobe, c2 done, c3 data register loaded
   a_ext_close_latch: assert property (
      s_close_quiet |=> s_latch_done)
      else $error("closing timing command did not latch and keep integrating");
   a_result_update: assert property (
      (integ.done && state_reg == lcs_pkg::LCS_ST_INTEG) |=> data_reg == $past(integ.result))
      else $error("result not copied on completion");
   a_once_powerdown: assert property (
      (integ.done && !cont_reg && state_reg == lcs_pkg::LCS_ST_INTEG && !wr)
      |=> !sensor_on ##1 data_reg == $past(data_reg))
      else $error("single conversion did not power down holding data");
   a_cont_keeps_running: assert property (
      (integ.done && cont_reg && on_reg && !wr) |=> sensor_on && integrating)
      else $error("continuous mode stopped after a conversion");
   a_powerdown_cmd: assert property (
      (wr_cmd1 && wmode == `LCS_MODE_OFF) |=> !sensor_on && !integrating)
      else $error("power-down command did not stop conversion");
   a_source_select: assert property (
      (wr_cmd1 && wmode == `LCS_MODE_IR) |=> ir_select && sensor_on)
      else $error("infrared mode did not select infrared array");
   a_range_bits: assert property (
      (wr && addr == `LCS_ADDR_CMD2) |=> range_sel == $past(wdata[1:0]))
      else $error("range not taken from low bits");
   a_read_bytes: assert property (
      (rd && addr == `LCS_ADDR_DATA_MSB && !(integ.done && on_reg))
      |=> rdata == data_reg[15:8] ##1 rdata == 8'h00 || $past(rd))
      else $error("high result byte misread");

   a_ext_open: assert property (
      s_open_cmd |=> integrating && integ.start)
      else $error("first timing command did not open the window");
   a_once_start: assert property (
      wr_once |=> sensor_on && ir_select == $past(wdata[0]))
      else $error("single conversion did not start on the chosen array");
   a_cont_start: assert property (
      (wr_cmd1 && wmode == `LCS_MODE_ALS && !ext_reg) |=> sensor_on && integrating && !ir_select)
      else $error("ambient continuous mode did not start");
   a_reserved_ignored: assert property (
      (wr_cmd1 && !(wmode inside {`LCS_MODE_OFF, `LCS_MODE_ALS, `LCS_MODE_IR}) && !integ.done)
      |=> $stable(sensor_on) && $stable(integrating))
      else $error("reserved mode code changed the conversion state");
   a_data_hold_off: assert property (
      (state_reg == lcs_pkg::LCS_ST_OFF) |=> $stable(data_reg))
      else $error("result changed while powered down");
   a_range_held: assert property (
      !(wr && addr == `LCS_ADDR_CMD2) |=> $stable(range_sel))
      else $error("range changed without a write");

   // ----------------------------------------
   // read path checks
   // ----------------------------------------
   // idle bus reads zero so stale bytes never leak
   a_read_idle: assert property (
      !rd |=> rdata == 8'h00)
      else $error("read data not cleared when idle");
   a_read_low_byte: assert property (
      (rd && addr == `LCS_ADDR_DATA_LSB) |=> rdata == $past(data_reg[7:0]))
      else $error("low result byte misread");
endmodule
`default_nettype wire

// ### test/lcs_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcs_front_model (
   // control
   input wire logic enable,
   input wire logic [1:0] osc_per_pulse,
   // analog side outputs
   output logic osc_clk,
   output logic charge_pulse
);
   int ph;
   initial begin
      osc_clk = 1'b0;
      charge_pulse = 1'b0;
      ph = 0;
   end
   always #80 osc_clk = ~osc_clk;
   // pulses midway between oscillator rises, wide enough to be seen
   always @(negedge osc_clk) begin
      ph = (ph + 1) % osc_per_pulse;
      if (enable && ph == 0) begin
         charge_pulse = 1'b1;
         #40 charge_pulse = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### test/test_light_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_light_adc_conversion_sequencer;
   logic mclk, nrst, wr, rd, osc_clk, charge_pulse, sensor_on, ir_select, integrating;
   logic [7:0] addr, wdata, rdata, v, lo, hi;
   logic [1:0] rate, range_sel;
   logic [15:0] got, prev;
   int n_errors, n_compared, seed, k, r;
   lcs_sequencer #(.CNT_W(16)) u_dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .osc_clk(osc_clk), .charge_pulse(charge_pulse),
      .sensor_on(sensor_on), .ir_select(ir_select), .integrating(integrating),
      .range_sel(range_sel));
   lcs_front_model u_front (.enable(sensor_on), .osc_per_pulse(rate), .osc_clk(osc_clk),
      .charge_pulse(charge_pulse));
   always #2 mclk = ~mclk;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic int exp_count(input logic [1:0] res, input int per);
      return (1 << (16 - 4 * res)) / per;
   endfunction
   task automatic final_report;
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // phase of charge pulses against the window allows one count either way
   task automatic near(input logic [15:0] g, input int e);
      n_compared++;
      if ($isunknown(g) || int'(g) < e - 1 || int'(g) > e + 1) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
      #1;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic rd16;
      rreg(8'h02, lo);
      rreg(8'h03, hi);
      got = {hi, lo};
   endtask
   task automatic wait_off;
      k = 0;
      while (sensor_on !== 1'b0 && k < 20000) begin
         @(posedge mclk);
         #1;
         k++;
      end
      chk(sensor_on, 1'b0);
   endtask
   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   initial begin
      // tests need about 60 us; three times that catches a hang
      #200000;
      n_errors++;
      final_report();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      rate = 2'h1;
      seed = 32'hadf2b2f0;
      n_errors = 0;
      n_compared = 0;
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      for (r = 0; r < 4; r++) begin
         rreg(r[7:0], v);
         chk(v, 16'h0000);
      end
      chk(sensor_on, 1'b0);
      $display("test reset done");
      repeat (4) begin
         v = 8'($random(seed));
         wreg(8'h01, {6'h03, v[1:0]});
         chk(range_sel, v[1:0]);
         rreg(8'h01, lo);
         chk(lo, {6'h03, v[1:0]});
      end
      $display("test range done");
      for (r = 0; r < 8; r++) begin
         wreg(8'h00, {r[2:0], 5'h00});
         chk(sensor_on, r == 5 || r == 6);
         if (r == 5 || r == 6) chk(ir_select, r == 6);
         wreg(8'h00, 8'h00);
         chk(sensor_on, 1'b0);
      end
      $display("test modes done");
      for (r = 3; r >= 2; r--) begin
         wreg(8'h01, {4'h0, r[1:0], 2'h0});
         v = 8'($random(seed));
         wreg(8'h0A, {7'h00, v[0]});
         chk(ir_select, v[0]);
         chk(integrating, 1'b1);
         wait_off();
         rd16();
         near(got, exp_count(r[1:0], 1));
         prev = got;
         repeat (300) @(posedge mclk);
         rd16();
         chk(got, prev);
         chk(sensor_on, 1'b0);
      end
      $display("test one-shot done");
      rate <= 2'h2;
      wreg(8'h01, 8'h0C);
      wreg(8'h00, 8'hA0);
      repeat (1400) @(posedge mclk);
      rd16();
      near(got, exp_count(2'h3, 2));
      rate <= 2'h1;
      repeat (1400) @(posedge mclk);
      rd16();
      near(got, exp_count(2'h3, 1));
      wreg(8'h00, 8'h00);
      chk(sensor_on, 1'b0);
      chk(integrating, 1'b0);
      $display("test continuous done");
      wreg(8'h08, 8'h01);
      wreg(8'h00, 8'hA0);
      chk(integrating, 1'b0);
      wreg(8'h09, 8'h00);
      chk(integrating, 1'b1);
      v = 8'($random(seed));
      // host sets the window; bench scales it down
      r = 4 + v[2:0];
      repeat (r * 40) @(posedge mclk);
      wreg(8'h09, 8'h00);
      chk(integrating, 1'b1);
      repeat (3) @(posedge mclk);
      rd16();
      near(got, r);
      wreg(8'h00, 8'h00);
      wreg(8'h08, 8'h00);
      $display("test external timing done");
      rd16();
      prev = got;
      v = 8'($random(seed));
      wreg(8'h02, v);
      wreg(8'h03, ~v);
      rd16();
      chk(got, prev);
      rreg(8'h55, v);
      chk(v, 8'h00);
      @(posedge mclk);
      #1;
      chk(rdata, 8'h00);
      $display("test read-only done");
      nrst <= 1'b0;
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      rd16();
      chk(got, 16'h0000);
      chk(sensor_on, 1'b0);
      $display("test second reset done");
      final_report();
   end
endmodule
`default_nettype wire
